// File: design/cms_pkg.sv
package cms_pkg;

    // register byte offsets
    localparam logic [7:0] CMS_OFS_SECOND_CFG  = 8'h00;
    localparam logic [7:0] CMS_OFS_CTRL_SWITCH = 8'h04;
    localparam logic [7:0] CMS_OFS_SERVO_CMD   = 8'h08;
    localparam logic [7:0] CMS_OFS_ASSIGN_LO   = 8'h0C;
    localparam logic [7:0] CMS_OFS_ASSIGN_HI   = 8'h10;
    localparam logic [7:0] CMS_OFS_STATUS      = 8'h14;

    // field positions
    localparam int CMS_SEC_MODE_LSB   = 0;
    localparam int CMS_SEC_CARRY_LSB  = 12;
    localparam int CMS_RET_CARRY_BIT  = 2;
    localparam int CMS_ANALOG_BIT     = 0;
    localparam int CMS_SWITCH_REQ_BIT = 9;

    // field values
    localparam logic [3:0] CMS_CARRY_KEEP  = 4'h1;
    localparam logic [7:0] CMS_FN_SWITCH   = 8'h10;
    localparam int         CMS_NUM_INPUTS  = 8;

    // reset values
    localparam logic [15:0] CMS_SECOND_CFG_RST  = 16'h0000;
    localparam logic [15:0] CMS_CTRL_SWITCH_RST = 16'h0000;
    localparam logic [15:0] CMS_SERVO_CMD_RST   = 16'h0000;
    localparam logic [31:0] CMS_ASSIGN_RST      = 32'h0000_0000;

    // control mode codes, shared by first and second mode
    typedef enum logic [3:0] {
        CMS_MODE_NONE     = 4'h0,
        CMS_MODE_POSITION = 4'h1,
        CMS_MODE_SPEED    = 4'h2,
        CMS_MODE_CURRENT  = 4'h3
    } cms_mode_e;

    // source of the position command
    typedef enum logic [1:0] {
        CMS_PSRC_REALTIME = 2'h0,
        CMS_PSRC_PROFILE  = 2'h1,
        CMS_PSRC_PULSE    = 2'h2
    } cms_psrc_e;

    // ahb-lite request as seen in the address phase
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } cms_ahb_req_s;

    // what the control loops are told
    typedef struct packed {
        logic [3:0]  mode;
        logic        second_active;
        logic        use_analog;
        logic        cmd_init;
        logic [31:0] init_value;
    } cms_loop_s;

endpackage : cms_pkg

// File: design/cms_switcher.sv
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
// How it works
// - the low four bits of the second-mode word pick none, position, speed or current.
// - bits 12 to 15 say whether entering the second mode resets or keeps the command.
// - returning to the first mode keeps the command only if the return bit is set.
// - speed and current take their command from the parameter or the analog input.
// - position carry-over is honoured only for profile commands, else position is forced.
// - only position, speed or current are accepted as the second mode.
// - the mode-switch bit of the servo command word requests the switch.
// - any input assigned function 16 also requests the switch.
module cms_switcher #(
    parameter int POS_W = 32
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 ce,
    input  wire cms_pkg::cms_ahb_req_s ahb_req,
    input  wire logic [31:0]          hwdata,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic [7:0]           din_pins,
    input  wire logic [3:0]           first_mode,
    input  wire logic [1:0]           pos_source,
    input  wire logic [POS_W-1:0]     position_now,
    output cms_pkg::cms_loop_s        loop_out
);
    import cms_pkg::*;

    // register bank
    logic [15:0] second_cfg_q,  second_cfg_d;
    logic [15:0] ctrl_switch_q, ctrl_switch_d;
    logic [15:0] servo_cmd_q,   servo_cmd_d;
    logic [31:0] assign_lo_q,   assign_lo_d;
    logic [31:0] assign_hi_q,   assign_hi_d;
    // bus data phase
    logic        wr_pend_q,  wr_pend_d;
    logic [7:0]  wr_addr_q,  wr_addr_d;
    logic [31:0] rdata_q,    rdata_d;
    // pin synchroniser
    logic [7:0]  din_s1_q, din_s2_q;
    // switching state
    logic        second_q, second_d;
    cms_loop_s   loop_q,   loop_d;

    logic        take;
    logic [3:0]  sec_mode;
    logic        sw_enable;
    logic        pin_req;
    logic        req;
    logic [31:0] status_word;

    // true when a mode code is one of the three loop modes
    function automatic logic cms_mode_ok(input logic [3:0] m);
        cms_mode_ok = (m == CMS_MODE_POSITION) || (m == CMS_MODE_SPEED) ||
                      (m == CMS_MODE_CURRENT);
    endfunction : cms_mode_ok

    // function code assigned to input pin i
    function automatic logic [7:0] cms_fn_of(input logic [31:0] lo,
                                             input logic [31:0] hi,
                                             input int          i);
        logic [63:0] all;
        all       = {hi, lo};
        cms_fn_of = all[i*8 +: 8];
    endfunction : cms_fn_of

    // address phase accepted: nonseq or seq with the bus ready
    assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];

    // second mode decode; codes above current count as disabled
    assign sec_mode  = second_cfg_q[CMS_SEC_MODE_LSB +: 4];
    assign sw_enable = cms_mode_ok(sec_mode);

    // request from any pin that carries the switch function
    always_comb
    begin
        pin_req = 1'b0;
        for (int i = 0; i < CMS_NUM_INPUTS; i++)
        begin
            if (cms_fn_of(assign_lo_q, assign_hi_q, i) == CMS_FN_SWITCH &&
                din_s2_q[i])
                pin_req = 1'b1;
        end
    end

    assign req = servo_cmd_q[CMS_SWITCH_REQ_BIT] || pin_req;

    assign status_word = {24'h00_0000, 1'b0, loop_q.use_analog,
                          sw_enable, second_q, loop_q.mode};

    // register writes land in the data phase, reads are fetched early
    always_comb
    begin
        second_cfg_d  = second_cfg_q;
        ctrl_switch_d = ctrl_switch_q;
        servo_cmd_d   = servo_cmd_q;
        assign_lo_d   = assign_lo_q;
        assign_hi_d   = assign_hi_q;
        wr_pend_d     = wr_pend_q;
        wr_addr_d     = wr_addr_q;
        rdata_d       = rdata_q;
        if (wr_pend_q)
        begin
            case (wr_addr_q)
                CMS_OFS_SECOND_CFG:  second_cfg_d  = hwdata[15:0];
                CMS_OFS_CTRL_SWITCH: ctrl_switch_d = hwdata[15:0];
                CMS_OFS_SERVO_CMD:   servo_cmd_d   = hwdata[15:0];
                CMS_OFS_ASSIGN_LO:   assign_lo_d   = hwdata;
                CMS_OFS_ASSIGN_HI:   assign_hi_d   = hwdata;
                default:             second_cfg_d  = second_cfg_q;
            endcase
        end
        if (ahb_req.hready)
        begin
            wr_pend_d = take && ahb_req.hwrite;
            wr_addr_d = ahb_req.haddr[7:0];
        end
        if (take && !ahb_req.hwrite)
        begin
            // status reflects state one cycle old; good enough for polling
            case (ahb_req.haddr[7:0])
                CMS_OFS_SECOND_CFG:  rdata_d = {16'h0000, second_cfg_q};
                CMS_OFS_CTRL_SWITCH: rdata_d = {16'h0000, ctrl_switch_q};
                CMS_OFS_SERVO_CMD:   rdata_d = {16'h0000, servo_cmd_q};
                CMS_OFS_ASSIGN_LO:   rdata_d = assign_lo_q;
                CMS_OFS_ASSIGN_HI:   rdata_d = assign_hi_q;
                CMS_OFS_STATUS:      rdata_d = status_word;
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            second_cfg_q  <= CMS_SECOND_CFG_RST;
            ctrl_switch_q <= CMS_CTRL_SWITCH_RST;
            servo_cmd_q   <= CMS_SERVO_CMD_RST;
            assign_lo_q   <= CMS_ASSIGN_RST;
            assign_hi_q   <= CMS_ASSIGN_RST;
            wr_pend_q     <= 1'b0;
            wr_addr_q     <= 8'h00;
            rdata_q       <= 32'h0000_0000;
        end
        else if (ce)
        begin
            second_cfg_q  <= second_cfg_d;
            ctrl_switch_q <= ctrl_switch_d;
            servo_cmd_q   <= servo_cmd_d;
            assign_lo_q   <= assign_lo_d;
            assign_hi_q   <= assign_hi_d;
            wr_pend_q     <= wr_pend_d;
            wr_addr_q     <= wr_addr_d;
            rdata_q       <= rdata_d;
        end
    end

    // zero wait states; a frozen clock enable also freezes the bus
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // two-stage synchroniser on the input pins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
        end
        else if (ce)
        begin
            din_s1_q <= din_pins;
            din_s2_q <= din_s1_q;
        end
    end

    // mode selection and command hand-over at each switch edge
    always_comb
    begin
        logic        carry;
        logic [3:0]  new_mode;
        carry    = 1'b0;
        new_mode = first_mode;
        second_d = req && sw_enable;
        loop_d   = loop_q;
        loop_d.cmd_init = 1'b0;
        if (second_d != second_q)
        begin
            if (second_d)
            begin
                // command was preloaded by the host before the request
                carry = second_cfg_q[CMS_SEC_CARRY_LSB +: 4]
                        == CMS_CARRY_KEEP;
                new_mode = sec_mode;
            end
            else
            begin
                carry = ctrl_switch_q[CMS_RET_CARRY_BIT];
            end
            // only profile commands can be carried in position mode
            if (new_mode == CMS_MODE_POSITION &&
                pos_source != CMS_PSRC_PROFILE)
                carry = 1'b0;
            loop_d.cmd_init = !carry;
            loop_d.init_value = (new_mode == CMS_MODE_POSITION) ?
                                32'(position_now) : 32'h0000_0000;
        end
        loop_d.second_active = second_d;
        // an invalid first mode is passed on as is; the host must avoid it
        loop_d.mode = second_d ? sec_mode : first_mode;
        loop_d.use_analog = ctrl_switch_q[CMS_ANALOG_BIT] &&
                            (loop_d.mode == CMS_MODE_SPEED ||
                             loop_d.mode == CMS_MODE_CURRENT);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            second_q <= 1'b0;
            loop_q   <= '0;
        end
        else if (ce)
        begin
            second_q <= second_d;
            loop_q   <= loop_d;
        end
    end

    assign loop_out = loop_q;

endmodule : cms_switcher

// File: verification/cms_checker.sv
`timescale 1ns/1ps
module cms_checker
    import cms_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  ce,
    input wire cms_pkg::cms_ahb_req_s ahb_req,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata,
    input wire logic [POS_W-1:0]      position_now,
    input wire cms_pkg::cms_loop_s    loop_out
);
    // read data may only move after an accepted read address phase
    logic rd_acc;
    assign rd_acc = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1]
                    & ~ahb_req.hwrite & ce;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_ready; hreadyout == ce; endproperty
    a_ready: assert property (p_ready) else $error("stall wrong");
    property p_hold; !rd_acc |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("hrdata moved");
    property p_legal; loop_out.second_active |-> loop_out.mode inside
        {CMS_MODE_POSITION, CMS_MODE_SPEED, CMS_MODE_CURRENT}; endproperty
    a_legal: assert property (p_legal) else $error("bad mode");
    property p_pulse; loop_out.cmd_init |=> !loop_out.cmd_init; endproperty
    a_pulse: assert property (p_pulse) else $error("init long");
    property p_on_sw;
        loop_out.cmd_init |-> $changed(loop_out.second_active);
    endproperty
    a_on_sw: assert property (p_on_sw) else $error("init no switch");
    property p_pos; loop_out.cmd_init && loop_out.mode == CMS_MODE_POSITION
        |-> loop_out.init_value == 32'($past(position_now)); endproperty
    a_pos: assert property (p_pos) else $error("pos init wrong");
    property p_zero; loop_out.cmd_init && loop_out.mode != CMS_MODE_POSITION
        |-> loop_out.init_value == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("init not zero");
endmodule : cms_checker

bind cms_switcher cms_checker #(.POS_W(POS_W)) cms_checker_i (
    .clk(clk), .rst_b(rst_b), .ce(ce), .ahb_req(ahb_req),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .position_now(position_now), .loop_out(loop_out));

// File: verification/cms_din_model.sv
`timescale 1ns/1ps
module cms_din_model (
    input  wire logic       clk,
    input  wire logic [2:0] pin_sel,
    input  wire logic       level,
    output logic [7:0]      din_pins
);
    // outside switch on one pin; the others rest at their idle low
    initial din_pins = 8'h00;
    always @(posedge clk)
    begin
        din_pins <= 8'(level) << pin_sel;
    end
endmodule : cms_din_model

// File: verification/cms_switcher_tb.sv
`timescale 1ns/1ps
module cms_switcher_tb;
    import cms_pkg::*;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    cms_ahb_req_s req = '0;
    logic [31:0]  hwdata = '0, hrdata;
    logic         hreadyout, hresp, level = 1'b0, init_seen = 1'b0;
    logic [7:0]   din_pins;
    logic [3:0]   first_mode = 4'h1;
    logic         ce = 1'b1;
    logic [1:0]   pos_source = 2'h0;
    logic [31:0]  position_now = 32'h0000_1234;
    cms_loop_s    loop_out;
    int           n_errors = 0, n_checks = 0, cyc = 0;

    always #25 clk = ~clk;
    // the slave's hreadyout is the bus hready
    cms_switcher cms_switcher_i (.clk(clk), .rst_b(rst_b), .ce(ce),
        .ahb_req({req[39:1], hreadyout}), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .din_pins(din_pins), .first_mode(first_mode),
        .pos_source(pos_source), .position_now(position_now),
        .loop_out(loop_out));
    cms_din_model cms_din_model_i (.clk(clk), .pin_sel(3'h2),
        .level(level), .din_pins(din_pins));

    // a pulse lasts one cycle, so latch it for the next look
    always @(posedge clk)
        if (loop_out.cmd_init === 1'b1) init_seen <= 1'b1;

    // hang guard, well above the roughly 160 cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            final_report();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one whole-word single transfer, waits on hready in both phases
    task xfer(input logic wr_en, input logic [7:0] a,
              input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge clk);
        req <= '{1'b1, {24'h0, a}, 2'h2, wr_en, 3'h2, 1'b0};
        do @(posedge clk); while (hreadyout !== 1'b1);
        req <= '0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        xfer(1'b0, a, 32'h0, v);
        chk(v, exp);
    endtask : rd

    // switch latency is a few cycles at most, pins add two sync stages
    task expect_loop(input logic act, input logic [3:0] md,
                     input logic ini, input logic [31:0] iv);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk(32'(loop_out.second_active), 32'(act));
        chk(32'(loop_out.mode), 32'(md));
        chk(32'(init_seen), 32'(ini));
        if (ini) chk(loop_out.init_value, iv);
        init_seen = 1'b0;
    endtask : expect_loop

    task t_regs;
        rd(8'h00, 32'h0);
        wr(8'h00, 32'hFFFF_1002);
        rd(8'h00, 32'h0000_1002);
        rd(8'h14, 32'h0000_0021);
        wr(8'h10, 32'h0807_0605);
        rd(8'h10, 32'h0807_0605);
        wr(8'h18, 32'h5A5A_5A5A);
        rd(8'h18, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task t_switch;
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h0002);
        wr(8'h08, 32'h200);
        expect_loop(1'b1, 4'h2, 1'b1, 32'h0);
        chk(32'(loop_out.use_analog), 32'h1);
        wr(8'h08, 32'h0);
        expect_loop(1'b0, 4'h1, 1'b1, 32'h1234);
        $display("test switch done");
    endtask : t_switch

    task t_carry;
        wr(8'h04, 32'h4);
        wr(8'h00, 32'h1003);
        @(posedge clk) pos_source <= 2'h1;
        wr(8'h08, 32'h200);
        expect_loop(1'b1, 4'h3, 1'b0, 32'h0);
        wr(8'h08, 32'h0);
        expect_loop(1'b0, 4'h1, 1'b0, 32'h0);
        @(posedge clk) pos_source <= 2'h0;
        wr(8'h08, 32'h200);
        expect_loop(1'b1, 4'h3, 1'b0, 32'h0);
        wr(8'h08, 32'h0);
        expect_loop(1'b0, 4'h1, 1'b1, 32'h1234);
        $display("test carry done");
    endtask : t_carry

    task t_refuse;
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h200);
        expect_loop(1'b0, 4'h1, 1'b0, 32'h0);
        wr(8'h00, 32'h4);
        expect_loop(1'b0, 4'h1, 1'b0, 32'h0);
        wr(8'h08, 32'h0);
        $display("test refuse done");
    endtask : t_refuse

    task t_pin;
        @(posedge clk) first_mode <= 4'h2;
        wr(8'h00, 32'h0001);
        wr(8'h0C, 32'h0010_0000);
        expect_loop(1'b0, 4'h2, 1'b0, 32'h0);
        @(posedge clk) level <= 1'b1;
        expect_loop(1'b1, 4'h1, 1'b1, 32'h1234);
        // a low clock enable must hold the second mode despite the pin
        @(posedge clk) ce <= 1'b0;
        level <= 1'b0;
        expect_loop(1'b1, 4'h1, 1'b0, 32'h0);
        @(posedge clk) ce <= 1'b1;
        // return carry bit is still set, so the speed command is kept
        expect_loop(1'b0, 4'h2, 1'b0, 32'h0);
        $display("test pin done");
    endtask : t_pin

    task final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_switch();
        t_carry();
        t_refuse();
        t_pin();
        final_report();
    end
endmodule : cms_switcher_tb
